// *** ddr_burst_sram_port.sv ***
// Purpose: device side of a double-data-rate burst sram port
// Assumes: CLK oversamples the input clock pair; all pins synchronised
// Notes:   single clock; input clock edges become one-cycle enables
//
// Contract
// [R1] write data taken on both clock rises
// [R2] read words driven on both clock rises
// [R3] data lines released when no read
// [R4] low load strobe on true rise starts cycle
// [R5] every access moves exactly two words
// [R6] active-low byte selects, one per 9-bit lane
// [R7] byte selects sampled with their data word
// [R8] deselected lane leaves stored byte unchanged
// [R9] address sampled on true rise at load
// [R10] one address bus serves reads and writes
// [R11] storage is two equal 1M x 18 arrays
// [R12] read/write select high reads, low writes
// [R13] output valid marks driven read data
// [R14] only true clock rise starts an access
// [R15] read latency 2.5 cycles, one with pll off
// [R16] free-running echo clocks follow input clock
// [R17] reads complete; new read every true rise
// [R18] output valid low outside read words
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_port (
	input  wire logic                                  CLK,
	input  wire logic                                  SYS_RST,
	input  wire logic                                  K_IN,
	input  wire logic                                  K_N_IN,
	input  wire logic                                  LOAD_STROBE_N,
	input  wire logic                                  RW,
	input  wire logic                                  PLL_DISABLE_N,
	input  wire logic [sram_port_pkg::ADDR_W-1:0]      ADDR,
	input  wire logic [sram_port_pkg::LANES-1:0]       BYTE_LANE_WRITE_SELECT_N,
	input  wire logic [sram_port_pkg::DQ_W-1:0]        DQ_I,
	output logic      [sram_port_pkg::DQ_W-1:0]        DQ_O,
	output logic                                       DQ_OE,
	output logic                                       OUTPUT_VALID_FLAG,
	output logic                                       ECHO_CLOCK_OUT,
	output logic                                       ECHO_CLOCK_OUT_N,
	output logic                                       WR_READY
);
	import sram_port_pkg::*;

	// ************************************************
	// lane merge
	// ************************************************
	function automatic logic [DQ_W-1:0] lane_merge(
		input logic [DQ_W-1:0]  old_w,
		input logic [DQ_W-1:0]  new_w,
		input logic [LANES-1:0] sel_n
	);
		logic [DQ_W-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!sel_n[i]) begin
				res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W]; // [R6] [R8]
			end
		end
		return res;
	endfunction

	// ************************************************
	// pin synchroniser
	// ************************************************
	// whole pin set moves together so data and clock edges stay aligned
	pins_t pin_raw;
	pins_t pin_s1_q;
	pins_t pin_s2_q;
	logic  k_prev_q;
	logic  k_n_prev_q;

	assign pin_raw.k                        = K_IN;
	assign pin_raw.k_n                      = K_N_IN;
	assign pin_raw.load_strobe_n            = LOAD_STROBE_N;
	assign pin_raw.rw                       = RW;
	assign pin_raw.pll_disable_n            = PLL_DISABLE_N;
	assign pin_raw.addr                     = ADDR;
	assign pin_raw.dq                       = DQ_I;
	assign pin_raw.byte_lane_write_select_n = BYTE_LANE_WRITE_SELECT_N;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_s1_q   <= '{k: 1'b1, k_n: 1'b1, load_strobe_n: 1'b1, default: '0};
			pin_s2_q   <= '{k: 1'b1, k_n: 1'b1, load_strobe_n: 1'b1, default: '0};
			k_prev_q   <= 1'b1; // high: a release never looks like a rising edge
			k_n_prev_q <= 1'b1;
		end else begin
			pin_s1_q   <= pin_raw;
			pin_s2_q   <= pin_s1_q;
			k_prev_q   <= pin_s2_q.k;
			k_n_prev_q <= pin_s2_q.k_n;
		end
	end

	// ************************************************
	// edge and command decode
	// ************************************************
	wire k_rise    = pin_s2_q.k & ~k_prev_q;
	wire k_n_rise  = pin_s2_q.k_n & ~k_n_prev_q;
	wire half_edge = k_rise | k_n_rise;
	wire load      = k_rise & ~pin_s2_q.load_strobe_n;          // [R4] [R14]
	wire rd_cmd    = load & pin_s2_q.rw;                         // [R12]
	wire wr_cmd    = load & ~pin_s2_q.rw;                        // [R12]
	wire pll_on    = pin_s2_q.pll_disable_n;

	// ************************************************
	// storage
	// ************************************************
	logic [DQ_W-1:0] array0 [0:ARRAY_DEPTH-1];                  // [R11]
	logic [DQ_W-1:0] array1 [0:ARRAY_DEPTH-1];                  // [R11]

	// ************************************************
	// read pipeline
	// ************************************************
	rd_slot_t          slot_q [0:RD_SLOTS-1];
	rd_slot_t          slot_in;
	logic              rd_second_q;
	logic [ADDR_W-1:0] rd_addr_q;

	// second word follows on the very next half edge, so back-to-back reads never collide
	assign slot_in = rd_cmd      ? rd_slot_t'{vld: 1'b1, word_sel: 1'b0, addr: pin_s2_q.addr} :
	                 rd_second_q ? rd_slot_t'{vld: 1'b1, word_sel: 1'b1, addr: rd_addr_q}     :
	                 '0; // [R5] [R9] [R10]

	wire [2:0] rd_lat   = pll_on ? RD_LAT_PLL_HALF : RD_LAT_DLLOFF_HALF; // [R15]
	wire [2:0] out_idx  = rd_lat - 3'h1;
	rd_slot_t  out_slot;
	assign out_slot = slot_q[out_idx];
	wire [DQ_W-1:0] rd_word = out_slot.word_sel ? array1[out_slot.addr] : array0[out_slot.addr];

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rd_second_q <= 1'b0;
			rd_addr_q   <= '0;
			for (int i = 0; i < RD_SLOTS; i++) begin
				slot_q[i] <= '0;
			end
		end else if (half_edge) begin
			rd_second_q <= rd_cmd;                                  // [R17]
			if (rd_cmd) begin
				rd_addr_q <= pin_s2_q.addr;
			end
			slot_q[0] <= slot_in;
			for (int i = 1; i < RD_SLOTS; i++) begin
				slot_q[i] <= slot_q[i-1];
			end
		end
	end

	// ************************************************
	// output drivers
	// ************************************************
	logic [DQ_W-1:0] dq_o_q;
	logic            dq_oe_q;
	logic            valid_q;
	logic            echo_q;
	logic            echo_n_q;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dq_o_q  <= DQ_RST;
			dq_oe_q <= 1'b0;
			valid_q <= 1'b0;
		end else if (half_edge) begin
			dq_o_q  <= out_slot.vld ? rd_word : DQ_RST;          // [R2]
			dq_oe_q <= out_slot.vld;                             // [R3]
			valid_q <= out_slot.vld;                             // [R13] [R18]
		end
	end

	// echo follows the synchronised pair, so valid changes on its edges
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			echo_q   <= 1'b0;
			echo_n_q <= 1'b0;
		end else begin
			echo_q   <= pin_s2_q.k;                              // [R16]
			echo_n_q <= pin_s2_q.k_n;                            // [R16]
		end
	end

	assign DQ_O              = dq_o_q;
	assign DQ_OE             = dq_oe_q;
	assign OUTPUT_VALID_FLAG = valid_q;
	assign ECHO_CLOCK_OUT    = echo_q;
	assign ECHO_CLOCK_OUT_N  = echo_n_q;

	// ************************************************
	// write capture
	// ************************************************
	wr_state_t         wr_state_q;
	logic [ADDR_W-1:0] wr_addr_q;
	wr_word_t          cap_word;
	logic              cap_valid;
	logic              buf_in_ready;

	wire cap_first  = wr_cmd;                                    // [R1]
	wire cap_second = k_n_rise & (wr_state_q == W_WORD1);        // [R1] [R5]
	assign cap_valid = cap_first | cap_second;
	// selects ride in the same word as their data
	assign cap_word = '{addr:                     cap_first ? pin_s2_q.addr : wr_addr_q,
	                    word_sel:                 cap_second,
	                    data:                     pin_s2_q.dq,
	                    byte_lane_write_select_n: pin_s2_q.byte_lane_write_select_n}; // [R7]

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_state_q <= W_IDLE;
			wr_addr_q  <= '0;
		end else begin
			case (wr_state_q)
				W_IDLE: begin
					if (cap_first) begin
						wr_state_q <= W_WORD1;
						wr_addr_q  <= pin_s2_q.addr;            // [R9] [R10]
					end
				end
				W_WORD1: begin
					if (k_n_rise) begin
						wr_state_q <= W_IDLE;
					end
				end
				default: begin
					wr_state_q <= W_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// write buffer and array update
	// ************************************************
	wr_word_t drain_word;
	logic     drain_valid;
	// array port is single: a read fetch wins, the buffer waits a cycle
	wire      drain_ready = ~(half_edge & out_slot.vld);

	wr_buffer u_wr_buffer (
		.clk       (CLK),
		.rst       (SYS_RST),
		.in_valid  (cap_valid),
		.in_ready  (buf_in_ready),
		.in_word   (cap_word),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_word  (drain_word)
	);

	wire do_write = drain_valid & drain_ready;

	always_ff @(posedge CLK) begin
		if (do_write && !drain_word.word_sel) begin
			array0[drain_word.addr] <= lane_merge(array0[drain_word.addr], drain_word.data,
			                                      drain_word.byte_lane_write_select_n); // [R8]
		end
		if (do_write && drain_word.word_sel) begin
			array1[drain_word.addr] <= lane_merge(array1[drain_word.addr], drain_word.data,
			                                      drain_word.byte_lane_write_select_n); // [R8]
		end
	end

	logic wr_ready_q;

	// a word offered while both entries are full is lost; this flag warns the source
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_ready_q <= 1'b0;
		end else begin
			wr_ready_q <= buf_in_ready;
		end
	end

	assign WR_READY = wr_ready_q;
endmodule
`default_nettype wire

// *** sram_port_pkg.sv ***
// Purpose: shared widths, latencies and carriers of the burst sram port
// Assumes: narrow variant, two arrays of 1M x 18
// Notes:   latencies counted in half cycles of the input clock pair
package sram_port_pkg;

	// ************************************************
	// geometry
	// ************************************************
	localparam int DQ_W        = 18;
	localparam int LANE_W      = 9;
	localparam int LANES       = 2;
	localparam int ADDR_W      = 20;
	localparam int ARRAY_DEPTH = 1 << ADDR_W;
	localparam int BURST_LEN   = 2;

	// ************************************************
	// read latency, in half cycles of the input clock
	// ************************************************
	localparam logic [2:0] RD_LAT_PLL_HALF    = 3'h5;
	localparam logic [2:0] RD_LAT_DLLOFF_HALF = 3'h2;
	localparam int         RD_SLOTS           = 5;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [DQ_W-1:0] DQ_RST    = 18'h00000;
	localparam logic [1:0]      FIFO_RST  = 2'h0;

	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic              k;
		logic              k_n;
		logic              load_strobe_n;
		logic              rw;
		logic              pll_disable_n;
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0]   dq;
		logic [LANES-1:0]  byte_lane_write_select_n;
	} pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              word_sel;
		logic [DQ_W-1:0]   data;
		logic [LANES-1:0]  byte_lane_write_select_n;
	} wr_word_t;

	typedef struct packed {
		logic              vld;
		logic              word_sel;
		logic [ADDR_W-1:0] addr;
	} rd_slot_t;

	typedef enum logic [0:0] {
		W_IDLE  = 1'b0,
		W_WORD1 = 1'b1
	} wr_state_t;

endpackage

// *** wr_buffer.sv ***
// Purpose: two-entry buffer for captured write words
// Assumes: single clock, async active-high reset
// Notes:   in_ready falls only when both entries hold words
`timescale 1ns/1ps
`default_nettype none
module wr_buffer (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    in_valid,
	output logic                         in_ready,
	input  wire sram_port_pkg::wr_word_t in_word,
	output logic                         out_valid,
	input  wire logic                    out_ready,
	output sram_port_pkg::wr_word_t      out_word
);
	import sram_port_pkg::*;

	wr_word_t   ent_q [0:1];
	logic       wr_ptr_q;
	logic       rd_ptr_q;
	logic [1:0] count_q;
	wire        push = in_valid & in_ready;
	wire        pop  = out_valid & out_ready;

	assign in_ready  = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_word  = ent_q[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			ent_q[wr_ptr_q] <= in_word;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= FIFO_RST;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule
`default_nettype wire

// *** kclk_model.sv ***
// Purpose: controller-side input clock pair for the sram port
// Assumes: HALF system clocks per half period of the pair
// Notes:   free running, moves on falling CLK only
`timescale 1ns/1ps
`default_nettype none
module kclk_model #(parameter int HALF = 8) (
	input  wire logic CLK,
	output var logic  K_IN,
	output logic      K_N_IN
);
	int cnt = 0;
	initial K_IN = 1'b0;
	// complementary rise is the true fall
	assign K_N_IN = ~K_IN;
	always @(negedge CLK) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) K_IN <= ~K_IN;
	end
endmodule
`default_nettype wire

// *** sram_port_chk.sv ***
// Purpose: port-level checks of the burst sram port
// Assumes: input clock half period of 8 CLK
// Notes:   burst length in CLK follows that half period
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk (
	input wire logic                          CLK,
	input wire logic                          SYS_RST,
	input wire logic                          K_IN,
	input wire logic                          K_N_IN,
	input wire logic                          LOAD_STROBE_N,
	input wire logic                          RW,
	input wire logic                          PLL_DISABLE_N,
	input wire logic [sram_port_pkg::DQ_W-1:0] DQ_O,
	input wire logic                          DQ_OE,
	input wire logic                          OUTPUT_VALID_FLAG,
	input wire logic                          ECHO_CLOCK_OUT,
	input wire logic                          ECHO_CLOCK_OUT_N
);
	logic       k_q;
	logic [7:0] rd_age_q;
	logic [7:0] edge_age_q;
	logic [2:0] warm_q;
	wire        rd_seen = K_IN && !k_q && !LOAD_STROBE_N && RW;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			k_q <= 1'b0;
			rd_age_q <= 8'hff;
			edge_age_q <= 8'hff;
			warm_q <= 3'h0;
		end else begin
			k_q <= K_IN;
			warm_q <= (warm_q == 3'h4) ? warm_q : warm_q + 3'h1;
			if (K_IN && !k_q && !LOAD_STROBE_N && RW) rd_age_q <= 8'h00;
			else if (rd_age_q != 8'hff) rd_age_q <= rd_age_q + 8'h01;
			if (K_IN != k_q) edge_age_q <= 8'h00;
			else if (edge_age_q != 8'hff) edge_age_q <= edge_age_q + 8'h01;
		end
	end
	// one burst word lasts one half period
	sequence s_word;
		DQ_OE [*8];
	endsequence
	property p_vld_oe;
		OUTPUT_VALID_FLAG == DQ_OE;
	endproperty
	a_vld_oe: assert property (p_vld_oe) else $error("valid flag differs from drive");
	property p_idle_zero;
		!DQ_OE |-> DQ_O == '0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("data nonzero while released");
	property p_echo;
		warm_q == 3'h4 |-> ECHO_CLOCK_OUT == $past(K_IN, 3);
	endproperty
	a_echo: assert property (p_echo) else $error("echo clock off its input");
	property p_echo_n;
		warm_q == 3'h4 |-> ECHO_CLOCK_OUT_N == $past(K_N_IN, 3);
	endproperty
	a_echo_n: assert property (p_echo_n) else $error("inverted echo off its input");
	// counted from the command: back-to-back reads would restart an age counter
	property p_lat;
		rd_seen && PLL_DISABLE_N |-> ##[40:44] DQ_OE;
	endproperty
	a_lat: assert property (p_lat) else $error("read data at wrong latency");
	property p_lat_off;
		rd_seen && !PLL_DISABLE_N |-> ##[16:20] DQ_OE;
	endproperty
	a_lat_off: assert property (p_lat_off) else $error("read data late with pll off");
	property p_align;
		$rose(DQ_OE) |-> edge_age_q >= 8'd1 && edge_age_q <= 8'd6;
	endproperty
	a_align: assert property (p_align) else $error("read word not on clock edge");
	property p_burst;
		$rose(DQ_OE) |-> s_word ##1 s_word;
	endproperty
	a_burst: assert property (p_burst) else $error("read burst cut short");
	property p_bounded;
		DQ_OE |-> rd_age_q <= 8'd62;
	endproperty
	a_bounded: assert property (p_bounded) else $error("drive without recent read");
endmodule
bind ddr_burst_sram_port sram_port_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .K_IN(K_IN),
	.K_N_IN(K_N_IN), .LOAD_STROBE_N(LOAD_STROBE_N), .RW(RW), .PLL_DISABLE_N(PLL_DISABLE_N),
	.DQ_O(DQ_O), .DQ_OE(DQ_OE), .OUTPUT_VALID_FLAG(OUTPUT_VALID_FLAG),
	.ECHO_CLOCK_OUT(ECHO_CLOCK_OUT), .ECHO_CLOCK_OUT_N(ECHO_CLOCK_OUT_N));
`default_nettype wire

// *** tb_ddr_burst_sram_port.sv ***
// Purpose: self-checking bench of the burst sram port
// Assumes: input clock pair 8 CLK per half period
// Notes:   every half edge is checked 6 CLK after the pin edge
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_burst_sram_port;
	import sram_port_pkg::*;
	logic              CLK = 1'b0, SYS_RST = 1'b1, LOAD_STROBE_N = 1'b1, RW = 1'b0;
	logic              PLL_DISABLE_N = 1'b1, K_IN, K_N_IN, DQ_OE, OUTPUT_VALID_FLAG;
	logic              ECHO_CLOCK_OUT, ECHO_CLOCK_OUT_N, WR_READY;
	logic [ADDR_W-1:0] ADDR = '0;
	logic [LANES-1:0]  BYTE_LANE_WRITE_SELECT_N = '1;
	logic [DQ_W-1:0]   DQ_I = '0, DQ_O;
	logic [DQ_W-1:0]   exp_q [int], m0 [int], m1 [int];
	int                fails = 0, num_checks = 0, half = 0, lat = 5, cyc = 0;
	kclk_model #(.HALF(8)) u_k (.CLK(CLK), .K_IN(K_IN), .K_N_IN(K_N_IN));
	ddr_burst_sram_port dut (.CLK(CLK), .SYS_RST(SYS_RST), .K_IN(K_IN), .K_N_IN(K_N_IN),
		.LOAD_STROBE_N(LOAD_STROBE_N), .RW(RW), .PLL_DISABLE_N(PLL_DISABLE_N), .ADDR(ADDR),
		.BYTE_LANE_WRITE_SELECT_N(BYTE_LANE_WRITE_SELECT_N), .DQ_I(DQ_I), .DQ_O(DQ_O),
		.DQ_OE(DQ_OE), .OUTPUT_VALID_FLAG(OUTPUT_VALID_FLAG), .ECHO_CLOCK_OUT(ECHO_CLOCK_OUT),
		.ECHO_CLOCK_OUT_N(ECHO_CLOCK_OUT_N), .WR_READY(WR_READY));
	initial forever #2.5 CLK = ~CLK;
	task automatic check(input string nm, input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************
	// half-edge monitor
	// ****************
	always @(K_IN) begin
		half = half + 1;
		repeat (6) @(posedge CLK);
		#1;
		if (!SYS_RST && exp_q.exists(half)) begin
			check("drive", {17'h0, DQ_OE}, 18'h1);
			check("valid", {17'h0, OUTPUT_VALID_FLAG}, 18'h1);
			check("data", DQ_O, exp_q[half]);
		end else begin
			check("drive", {17'h0, DQ_OE}, 18'h0);
			check("valid", {17'h0, OUTPUT_VALID_FLAG}, 18'h0);
		end
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			summarize();
		end
	end
	function automatic logic [DQ_W-1:0] merge(logic [DQ_W-1:0] o, n, logic [LANES-1:0] s);
		for (int i = 0; i < LANES; i++) if (!s[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
		return o;
	endfunction
	// one command per true rise; word1 set up for the following complementary rise
	task automatic op(input logic ld_n, rw, input logic [ADDR_W-1:0] a,
		input logic [DQ_W-1:0] d0, d1, input logic [LANES-1:0] s0, s1);
		@(posedge K_N_IN);
		repeat (4) @(negedge CLK);
		LOAD_STROBE_N = ld_n;
		RW = rw;
		ADDR = a;
		DQ_I = d0;
		BYTE_LANE_WRITE_SELECT_N = s0;
		@(posedge K_IN);
		#1;
		if (!ld_n && rw) begin
			exp_q[half + lat] = m0[a];
			exp_q[half + lat + 1] = m1[a];
		end
		if (!ld_n && !rw) begin
			m0[a] = merge(m0.exists(a) ? m0[a] : 18'h0, d0, s0);
			m1[a] = merge(m1.exists(a) ? m1[a] : 18'h0, d1, s1);
		end
		repeat (4) @(negedge CLK);
		LOAD_STROBE_N = 1'b1;
		DQ_I = d1;
		BYTE_LANE_WRITE_SELECT_N = s1;
	endtask
	task automatic t_reset();
		repeat (8) @(negedge CLK);
		check("drive", {17'h0, DQ_OE}, 18'h0);
		SYS_RST = 1'b0;
		repeat (2) @(negedge CLK);
		check("ready", {17'h0, WR_READY}, 18'h1);
		$display("test reset done");
	endtask
	// full writes, then lane-masked overwrites, then back-to-back reads
	task automatic t_bytes();
		for (int a = 0; a < 4; a++) op(0, 0, a, 18'h2a5a5 ^ a, 18'h15a5a ^ a, 2'h0, 2'h0);
		for (int a = 0; a < 4; a++) op(0, 0, a, 18'h3ffff, 18'h00000, a[1:0], ~a[1:0]);
		op(1, 1, 0, 0, 0, 2'h3, 2'h3);
		// strobe low only around a complementary rise: no read may start
		@(negedge CLK);
		LOAD_STROBE_N = 1'b0;
		@(posedge K_N_IN);
		repeat (4) @(negedge CLK);
		LOAD_STROBE_N = 1'b1;
		for (int a = 0; a < 4; a++) op(0, 1, a, 0, 0, 2'h3, 2'h3);
		repeat (4) op(1, 0, 0, 0, 0, 2'h3, 2'h3);
		$display("test bytes done");
	endtask
	// mixed traffic on the high end of the address space
	task automatic t_mixed();
		for (int i = 0; i < 3; i++) begin
			op(0, 0, 20'hffffe + i[0], 18'h3c3c3 + i, 18'h0f0f0 - i, 2'h0, 2'h0);
			op(1, 1, 0, 0, 0, 2'h3, 2'h3);
			op(0, 1, 20'hffffe + i[0], 0, 0, 2'h3, 2'h3);
		end
		repeat (4) op(1, 0, 0, 0, 0, 2'h3, 2'h3);
		$display("test mixed done");
	endtask
	task automatic t_pll_off();
		@(negedge CLK);
		PLL_DISABLE_N = 1'b0;
		lat = 2;
		repeat (2) op(1, 0, 0, 0, 0, 2'h3, 2'h3);
		for (int a = 3; a >= 0; a--) op(0, 1, a, 0, 0, 2'h3, 2'h3);
		repeat (3) op(1, 0, 0, 0, 0, 2'h3, 2'h3);
		$display("test pll_off done");
	endtask
	initial begin
		t_reset();
		t_bytes();
		t_mixed();
		t_pll_off();
		summarize();
	end
endmodule
`default_nettype wire
